// *** hw/core_pkg.sv ***
// Shared constants and types for the core datapath.
// Assumes one core clock; quarter phases are counted inside the core.
package core_pkg;
	localparam int INSTR_W      = 14;
	localparam int DATA_W       = 8;
	localparam int FILE_AW      = 7;
	localparam int PROG_AW_1K   = 10;
	localparam int PROG_AW_512  = 9;
	localparam int RAM_DEPTH    = 128;

	// Instruction fields
	localparam int CLASS_HI     = 13;
	localparam int CLASS_LO     = 12;
	localparam int OP_HI        = 11;
	localparam int OP_LO        = 8;
	localparam int DEST_BIT     = 7;
	localparam int TARGET_HI    = 9;

	localparam logic [1:0] CLASS_FILE    = 2'h0;
	localparam logic [1:0] CLASS_BRANCH  = 2'h2;
	localparam logic [1:0] CLASS_LITERAL = 2'h3;

	localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

	// Special file addresses
	localparam logic [FILE_AW-1:0] ADDR_INDIRECT = 7'h00;
	localparam logic [FILE_AW-1:0] ADDR_IPTR_LO  = 7'h02;
	localparam logic [FILE_AW-1:0] ADDR_STATUS   = 7'h03;
	localparam logic [FILE_AW-1:0] ADDR_POINTER  = 7'h04;
	localparam logic [FILE_AW-1:0] ADDR_RAM_BASE = 7'h0C;

	// Status bit positions and reset values
	localparam int STATUS_CARRY  = 0;
	localparam int STATUS_NIBBLE = 1;
	localparam int STATUS_ZERO   = 2;
	localparam logic [DATA_W-1:0] STATUS_RESET  = 8'h18;
	localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
	localparam logic [DATA_W-1:0] W_RESET       = 8'h00;

	typedef enum logic [3:0] {
		OP_NOP, OP_MOVE, OP_STORE_W, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
		OP_COM, OP_INC, OP_DEC, OP_ROT_L, OP_ROT_R, OP_SWAP, OP_CLR, OP_PASS_W
	} alu_op_t;

	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;

	typedef struct packed {
		logic carry;
		logic nibble;
		logic zero;
	} alu_flags_t;

	typedef struct packed {
		logic [1:0]         iclass;
		alu_op_t            op;
		logic               to_file;
		logic [FILE_AW-1:0] faddr;
		logic [DATA_W-1:0]  literal;
	} decoded_t;
endpackage : core_pkg

// *** hw/file_ram.sv ***
// General purpose data memory of the core.
// Assumes single clock; read data appear one edge after the address.
`timescale 1ns/1ps
module file_ram #(
	parameter int DEPTH = 128,
	parameter int AW    = 7,
	parameter int DW    = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_check
		$error("file_ram depth exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read keeps the operand path off the decode timing
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : file_ram

// *** hw/harvard_core.sv ***
// Two-stage 8-bit core datapath: fetch, file operand, ALU, write back.
// Assumes external program memory answering combinationally on prog_data.
//
// Notes on behaviour
// RULE_01: One 14-bit word fetched per cycle
// RULE_02: Fetch of next overlaps current execute
// RULE_03: One cycle each; branch flushes fetch
// RULE_04: Pointer spans 512 or 1K words
// RULE_05: Special registers live in file space
// RULE_06: File reach direct or through pointer
// RULE_07: Every operation on every file address
// RULE_08: ALU 8 bits: add, sub, shift, logic
// RULE_09: Arithmetic is two's complement
// RULE_10: Two operands: accumulator with file/literal
// RULE_11: Single operand: accumulator or file
// RULE_12: Accumulator has no file address
// RULE_13: Carry, nibble, zero updated per instruction
// RULE_14: Subtract flags are inverted borrows
// RULE_15: Operand read Q2, result written Q4
// RULE_16: Zero flag set exactly on zero result
`timescale 1ns/1ps
module harvard_core #(
	parameter int PROG_AW = core_pkg::PROG_AW_1K
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic [core_pkg::INSTR_W-1:0] prog_data,
	output logic      [PROG_AW-1:0]           prog_addr,
	output logic      [core_pkg::DATA_W-1:0]  accumulator,
	output logic      [core_pkg::DATA_W-1:0]  status,
	output logic                              cycle_start
);
	localparam int DW = core_pkg::DATA_W;
	localparam int AW = core_pkg::FILE_AW;

	if (PROG_AW != core_pkg::PROG_AW_1K && PROG_AW != core_pkg::PROG_AW_512) begin : g_check
		$error("PROG_AW must select 512 or 1K words");
	end

	core_pkg::quarter_t            quarter_reg;
	logic [PROG_AW-1:0]            instruction_pointer_reg;
	logic [core_pkg::INSTR_W-1:0]  instr_reg;
	logic [DW-1:0]                 w_reg;
	logic [DW-1:0]                 status_reg;
	logic [DW-1:0]                 pointer_reg;
	logic [DW-1:0]                 operand_reg;
	logic [DW-1:0]                 result_reg;
	core_pkg::alu_flags_t          flags_reg;
	core_pkg::decoded_t            dec;
	logic [AW-1:0]                 eff_addr;
	logic                          is_ram;
	logic [DW-1:0]                 ram_rdata;
	logic                          ram_we;
	logic [DW-1:0]                 sfr_rdata;
	logic [DW-1:0]                 alu_a;
	logic [DW-1:0]                 alu_b;
	logic [DW-1:0]                 result_next;
	core_pkg::alu_flags_t          flags_next;
	logic [2:0]                    flag_mask;
	logic                          writes_file;
	logic                          writes_w;
	logic                          branch_now;
	logic [PROG_AW-1:0]            branch_target;

	assign dec.iclass  = instr_reg[core_pkg::CLASS_HI:core_pkg::CLASS_LO];
	assign dec.op      = core_pkg::alu_op_t'(instr_reg[core_pkg::OP_HI:core_pkg::OP_LO]);
	assign dec.to_file = instr_reg[core_pkg::DEST_BIT];
	assign dec.faddr   = instr_reg[AW-1:0];
	assign dec.literal = instr_reg[DW-1:0];

	// Address zero redirects through the pointer register [RULE_06]
	assign eff_addr = (dec.faddr == core_pkg::ADDR_INDIRECT) ? pointer_reg[AW-1:0] : dec.faddr;
	assign is_ram   = (eff_addr >= core_pkg::ADDR_RAM_BASE);

	// Quarter sequencer: four clocks make one instruction cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			quarter_reg <= core_pkg::Q1;
		end else begin
			case (quarter_reg)
				core_pkg::Q1: quarter_reg <= core_pkg::Q2;
				core_pkg::Q2: quarter_reg <= core_pkg::Q3;
				core_pkg::Q3: quarter_reg <= core_pkg::Q4;
				core_pkg::Q4: quarter_reg <= core_pkg::Q1;
				default:      quarter_reg <= core_pkg::Q1;
			endcase
		end
	end

	file_ram #(
		.DEPTH(core_pkg::RAM_DEPTH),
		.AW   (AW),
		.DW   (DW)
	) u_ram (
		.clk  (clk),
		.we   (ram_we),
		.waddr(eff_addr),
		.wdata(result_reg),
		.raddr(eff_addr),
		.rdata(ram_rdata)
	);

	// Special registers decoded in the same space as RAM [RULE_05]
	always_comb begin
		case (eff_addr)
			core_pkg::ADDR_IPTR_LO: sfr_rdata = DW'(instruction_pointer_reg);
			core_pkg::ADDR_STATUS:  sfr_rdata = status_reg;
			core_pkg::ADDR_POINTER: sfr_rdata = pointer_reg;
			default:                sfr_rdata = 8'h00;
		endcase
	end

	// Operand captured at the end of Q2, RAM data ready after Q1 edge [RULE_15]
	always_ff @(posedge clk) begin
		if (reset) begin
			operand_reg <= 8'h00;
		end else if (quarter_reg == core_pkg::Q2) begin
			operand_reg <= is_ram ? ram_rdata : sfr_rdata;
		end
	end

	// Literal class: constant from the word, single-operand ops use W [RULE_10] [RULE_11]
	assign alu_a = w_reg;
	always_comb begin
		case (dec.op)
			core_pkg::OP_COM, core_pkg::OP_INC, core_pkg::OP_DEC, core_pkg::OP_ROT_L,
			core_pkg::OP_ROT_R, core_pkg::OP_SWAP:
				alu_b = (dec.iclass == core_pkg::CLASS_LITERAL) ? w_reg : operand_reg;
			default:
				alu_b = (dec.iclass == core_pkg::CLASS_LITERAL) ? dec.literal : operand_reg;
		endcase
	end

	// Any op on any address, no per-register exceptions [RULE_07] [RULE_08] [RULE_09]
	always_comb begin
		logic [DW:0]   wide;
		logic [4:0]    low;
		wide        = '0;
		low         = '0;
		result_next = alu_b;
		flags_next  = '{carry: status_reg[core_pkg::STATUS_CARRY],
			nibble: status_reg[core_pkg::STATUS_NIBBLE], zero: 1'b0};
		flag_mask   = 3'h1;
		case (dec.op)
			core_pkg::OP_ADD: begin
				wide              = {1'b0, alu_b} + {1'b0, alu_a};
				low               = {1'b0, alu_b[3:0]} + {1'b0, alu_a[3:0]};
				result_next       = wide[DW-1:0];
				flags_next.carry  = wide[DW];
				flags_next.nibble = low[4];
				flag_mask         = 3'h7;
			end
			core_pkg::OP_SUB: begin
				// Add of inverse plus one: carry out is not-borrow [RULE_14]
				wide              = {1'b0, alu_b} + {1'b0, ~alu_a} + 9'h001;
				low               = {1'b0, alu_b[3:0]} + {1'b0, ~alu_a[3:0]} + 5'h01;
				result_next       = wide[DW-1:0];
				flags_next.carry  = wide[DW];
				flags_next.nibble = low[4];
				flag_mask         = 3'h7;
			end
			core_pkg::OP_AND: result_next = alu_a & alu_b;
			core_pkg::OP_IOR: result_next = alu_a | alu_b;
			core_pkg::OP_XOR: result_next = alu_a ^ alu_b;
			core_pkg::OP_COM: result_next = ~alu_b;
			core_pkg::OP_INC: result_next = alu_b + 8'h01;
			core_pkg::OP_DEC: result_next = alu_b - 8'h01;
			core_pkg::OP_ROT_L: begin
				result_next      = {alu_b[DW-2:0], status_reg[core_pkg::STATUS_CARRY]};
				flags_next.carry = alu_b[DW-1];
				flag_mask        = 3'h4;
			end
			core_pkg::OP_ROT_R: begin
				result_next      = {status_reg[core_pkg::STATUS_CARRY], alu_b[DW-1:1]};
				flags_next.carry = alu_b[0];
				flag_mask        = 3'h4;
			end
			core_pkg::OP_SWAP: begin
				result_next = {alu_b[3:0], alu_b[DW-1:4]};
				flag_mask   = 3'h0;
			end
			core_pkg::OP_STORE_W, core_pkg::OP_PASS_W: begin
				result_next = alu_a;
				flag_mask   = 3'h0;
			end
			core_pkg::OP_CLR: result_next = 8'h00;
			core_pkg::OP_MOVE: begin
				result_next = alu_b;
				flag_mask   = (dec.iclass == core_pkg::CLASS_LITERAL) ? 3'h0 : 3'h1;
			end
			default: begin
				result_next = alu_b;
				flag_mask   = 3'h0;
			end
		endcase
		flags_next.zero = (result_next == 8'h00); // [RULE_16]
	end

	// Result settles in Q3 ahead of the Q4 write
	always_ff @(posedge clk) begin
		if (reset) begin
			result_reg <= 8'h00;
			flags_reg  <= '0;
		end else if (quarter_reg == core_pkg::Q3) begin
			result_reg <= result_next;
			flags_reg  <= flags_next;
		end
	end

	// W is never a file target; non-NOP literal ops write it, file ops other than OP_NOP and OP_STORE_W write it when the destination bit is clear [RULE_12]
	assign writes_file = (dec.iclass == core_pkg::CLASS_FILE) && dec.op != core_pkg::OP_NOP
		&& (dec.to_file || dec.op == core_pkg::OP_STORE_W);
	assign writes_w    = (dec.iclass == core_pkg::CLASS_LITERAL && dec.op != core_pkg::OP_NOP)
		|| (dec.iclass == core_pkg::CLASS_FILE && dec.op != core_pkg::OP_NOP
		&& !dec.to_file && dec.op != core_pkg::OP_STORE_W);
	assign ram_we      = (quarter_reg == core_pkg::Q4) && writes_file && is_ram; // [RULE_15]

	always_ff @(posedge clk) begin
		if (reset) begin
			w_reg <= core_pkg::W_RESET;
		end else if (quarter_reg == core_pkg::Q4 && writes_w) begin
			w_reg <= result_reg; // [RULE_10]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pointer_reg <= core_pkg::POINTER_RESET;
		end else if (quarter_reg == core_pkg::Q4 && writes_file
				&& eff_addr == core_pkg::ADDR_POINTER) begin
			pointer_reg <= result_reg;
		end
	end

	// Flag update from the ALU overrides a plain write to status [RULE_13]
	always_ff @(posedge clk) begin
		if (reset) begin
			status_reg <= core_pkg::STATUS_RESET;
		end else if (quarter_reg == core_pkg::Q4 && dec.iclass != core_pkg::CLASS_BRANCH) begin
			if (writes_file && eff_addr == core_pkg::ADDR_STATUS) begin
				status_reg <= result_reg;
			end
			if (flag_mask[0]) begin
				status_reg[core_pkg::STATUS_ZERO] <= flags_reg.zero; // [RULE_16]
			end
			if (flag_mask[1]) begin
				status_reg[core_pkg::STATUS_NIBBLE] <= flags_reg.nibble; // [RULE_14]
			end
			if (flag_mask[2]) begin
				status_reg[core_pkg::STATUS_CARRY] <= flags_reg.carry; // [RULE_14]
			end
		end
	end

	// Jump or write to pointer low byte both redirect the fetch
	assign branch_now = (dec.iclass == core_pkg::CLASS_BRANCH)
		|| (writes_file && eff_addr == core_pkg::ADDR_IPTR_LO);
	always_comb begin
		branch_target = instruction_pointer_reg;
		if (dec.iclass == core_pkg::CLASS_BRANCH) begin
			branch_target = instr_reg[PROG_AW-1:0]; // [RULE_04]
		end else begin
			branch_target[DW-1:0] = result_reg;
		end
	end

	// Fetched word latched at end of Q4 while the current word executes [RULE_01] [RULE_02]
	always_ff @(posedge clk) begin
		if (reset) begin
			instruction_pointer_reg <= '0;
			instr_reg               <= core_pkg::NOP_WORD;
		end else if (quarter_reg == core_pkg::Q4) begin
			if (branch_now) begin
				instruction_pointer_reg <= branch_target;
				instr_reg               <= core_pkg::NOP_WORD; // [RULE_03]
			end else begin
				instruction_pointer_reg <= instruction_pointer_reg + 1'b1; // [RULE_04]
				instr_reg               <= prog_data; // [RULE_01]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prog_addr   <= '0;
			accumulator <= core_pkg::W_RESET;
			status      <= core_pkg::STATUS_RESET;
			cycle_start <= 1'b0;
		end else begin
			prog_addr   <= (quarter_reg == core_pkg::Q4) ?
				(branch_now ? branch_target : instruction_pointer_reg + 1'b1) :
				instruction_pointer_reg;
			accumulator <= w_reg;
			status      <= status_reg;
			cycle_start <= (quarter_reg == core_pkg::Q4);
		end
	end
endmodule : harvard_core

// *** test/prog_rom.sv ***
// Program memory model for the core's fetch port.
// Assumes the bench fills every word before reset is released.
`timescale 1ns/1ps
module prog_rom #(
	parameter int AW = 10
) (
	input  wire logic [AW-1:0] prog_addr,
	output logic      [13:0]   prog_data
);
	// Whole word per address, answered at once
	logic [13:0] mem [2**AW];
	assign prog_data = mem[prog_addr];
endmodule : prog_rom

// *** test/harvard_core_assertions.sv ***
// Port checker for the core datapath.
// Assumes it is bound to the top module of the core.
`timescale 1ns/1ps
module harvard_core_assertions #(
	parameter int PROG_AW = 10
) (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic [13:0]        prog_data,
	input wire logic [PROG_AW-1:0] prog_addr,
	input wire logic [7:0]         accumulator,
	input wire logic [7:0]         status,
	input wire logic               cycle_start
);
	logic [1:0]         q_cnt;
	logic               started;
	logic               jump_exec;
	logic [13:0]        exec_word;
	logic [13:0]        exec_prev;
	logic [PROG_AW-1:0] tgt_reg;
	logic               reset_hold_reg;
	wire take = started && q_cnt == 2'h3;
	wire jump_take = take && prog_data[13:12] == core_pkg::CLASS_BRANCH && !jump_exec;
	wire lit = exec_prev[13:12] == core_pkg::CLASS_LITERAL;
	wire [3:0] op = exec_prev[11:8];
	wire zop = lit && (op inside {[4'h3:4'hA], 4'hE});
	always_ff @(posedge clk) begin
		if (reset) begin
			q_cnt   <= 2'h0;
			started <= 1'b0;
		end else begin
			q_cnt   <= cycle_start ? 2'h1 : q_cnt + 2'h1;
			started <= started | cycle_start;
		end
	end
	// Words flushed by a jump logged as no-ops so flag checks skip them
	always_ff @(posedge clk) begin
		if (reset) begin
			jump_exec <= 1'b0;
			exec_word <= 14'h0000;
			exec_prev <= 14'h0000;
			tgt_reg   <= '0;
		end else if (take) begin
			jump_exec <= jump_take;
			exec_word <= jump_exec ? 14'h0000 : prog_data;
			exec_prev <= exec_word;
			if (jump_take) tgt_reg <= prog_data[PROG_AW-1:0];
		end
	end
	// Sync reset: outputs only settle one edge after release
	always_ff @(posedge clk) reset_hold_reg <= reset;
	default clocking @(posedge clk); endclocking
	default disable iff (reset || reset_hold_reg);
	chk_reset_state: assert property (disable iff (1'b0) reset ##1 reset |=>
		prog_addr == '0 && accumulator == 8'h00 && status == core_pkg::STATUS_RESET)
		else $error("state not cleared by reset");
	chk_cycle_period: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("instruction cycle not four clocks");
	chk_addr_steady: assert property (!cycle_start |-> $stable(prog_addr))
		else $error("fetch address moved inside a cycle");
	chk_jump_target: assert property (jump_take |-> ##6 prog_addr == tgt_reg)
		else $error("branch target not fetched");
	chk_flush_quiet: assert property (jump_take |-> ##3
		($stable(accumulator) && $stable(status)) [*8])
		else $error("discarded word changed state");
	chk_zero_flag: assert property ($changed(accumulator) && zop |->
		status[2] == (accumulator == 8'h00))
		else $error("zero flag wrong");
	chk_add_carry: assert property ($changed(accumulator) && lit && op == 4'h3 |->
		{status[0], accumulator} == 9'($past(accumulator)) + 9'(exec_prev[7:0]))
		else $error("add sum or carry wrong");
	chk_sub_borrow: assert property ($changed(accumulator) && lit && op == 4'h4 |->
		status[0] == (exec_prev[7:0] >= $past(accumulator)) &&
		status[1] == (exec_prev[3:0] >= $past(accumulator[3:0])))
		else $error("subtract borrow flags wrong");
	cover property (jump_take);
	cover property ($changed(accumulator) && lit && op == 4'h4);
	cover property (zop && status[2]);
endmodule : harvard_core_assertions

bind harvard_core harvard_core_assertions #(.PROG_AW(PROG_AW)) harvard_core_assertions_i (
	.clk, .reset, .prog_data, .prog_addr, .accumulator, .status, .cycle_start);

// *** test/harvard_core_tb.sv ***
// Testbench: runs an instruction table through the core and checks W and status.
// Assumes results show one clock after the fourth edge of each execute cycle.
`timescale 1ns/1ps
module harvard_core_tb;
	typedef struct packed {
		logic [13:0] word;
		logic [7:0]  acc;
		logic [7:0]  st;
	} row_t;
	localparam int N_ROWS = 24;
	localparam int JMP    = 24;
	logic        clk;
	logic        reset;
	logic [13:0] prog_data;
	logic [9:0]  prog_addr;
	logic [7:0]  accumulator;
	logic [7:0]  status;
	logic        cycle_start;
	int          edge_n;
	int          err_count;
	int          check_count;
	row_t        rows [N_ROWS] = '{
		'{14'h313A, 8'h3A, 8'h18}, '{14'h33C6, 8'h00, 8'h1F},
		'{14'h3105, 8'h05, 8'h1F}, '{14'h3403, 8'hFE, 8'h18},
		'{14'h3112, 8'h12, 8'h18}, '{14'h3434, 8'h22, 8'h1B},
		'{14'h350F, 8'h02, 8'h1B}, '{14'h3650, 8'h52, 8'h1B},
		'{14'h3752, 8'h00, 8'h1F}, '{14'h3800, 8'hFF, 8'h1B},
		'{14'h3900, 8'h00, 8'h1F}, '{14'h3A00, 8'hFF, 8'h1B},
		'{14'h3E00, 8'h00, 8'h1F}, '{14'h3C00, 8'h80, 8'h1E},
		'{14'h3B00, 8'h00, 8'h1F}, '{14'h313C, 8'h3C, 8'h1F},
		'{14'h3D00, 8'hC3, 8'h1F}, '{14'h028C, 8'hC3, 8'h1F},
		'{14'h310C, 8'h0C, 8'h1F}, '{14'h0284, 8'h0C, 8'h1F},
		'{14'h3100, 8'h00, 8'h1F}, '{14'h0100, 8'hC3, 8'h1B},
		'{14'h030C, 8'h86, 8'h19}, '{14'h0103, 8'h19, 8'h19}
	};

	harvard_core #(.PROG_AW(10)) harvard_core_i (
		.clk(clk),
		.reset(reset),
		.prog_data(prog_data),
		.prog_addr(prog_addr),
		.accumulator(accumulator),
		.status(status),
		.cycle_start(cycle_start)
	);
	prog_rom #(.AW(10)) prog_rom_i (
		.prog_addr(prog_addr),
		.prog_data(prog_data)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) edge_n <= reset ? 0 : edge_n + 1;

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte
	task automatic chk_addr(input string what, input logic [9:0] exp, input logic [9:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_addr
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// Bounded so a stalled core ends the run instead of hanging it
	task automatic at_edge(input int n);
		for (int i = 0; i < 400 && edge_n < n; i++) begin
			@(posedge clk);
			#1;
		end
		if (edge_n != n) begin
			err_count++;
			$display("[FAIL] edge wait expected %0d seen %0d", n, edge_n);
			tally_and_finish();
		end
	endtask : at_edge
	task automatic do_reset(input int n);
		@(posedge clk);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk_addr("reset addr", 10'h000, prog_addr);
		chk_byte("reset acc", 8'h00, accumulator);
		chk_byte("reset status", 8'h18, status);
		chk_byte("reset cycle start", 8'h00, {7'h00, cycle_start});
	endtask : do_reset

	initial begin
		reset = 1'b1;
		for (int a = 0; a < 1024; a++) prog_rom_i.mem[a] = 14'h0000;
		for (int k = 0; k < N_ROWS; k++) prog_rom_i.mem[k] = rows[k].word;
		// Word after the jump must be discarded, target sits past a gap
		prog_rom_i.mem[JMP]     = 14'h201E;
		prog_rom_i.mem[JMP + 1] = 14'h31EE;
		prog_rom_i.mem[30]      = 14'h315A;
		do_reset(4);
		for (int k = 0; k < N_ROWS; k++) begin
			at_edge(4 * (k + 2) + 2);
			chk_byte("acc", rows[k].acc, accumulator);
			chk_byte("status", rows[k].st, status);
			chk_addr("fetch addr", 10'(k + 2), prog_addr);
		end
		at_edge(4 * (JMP + 2) + 2);
		chk_addr("jump target", 10'h01E, prog_addr);
		at_edge(4 * (JMP + 3));
		chk_byte("cycle start", 8'h01, {7'h00, cycle_start});
		at_edge(4 * (JMP + 3) + 2);
		chk_byte("flushed acc", 8'h19, accumulator);
		at_edge(4 * (JMP + 4) + 2);
		chk_byte("target acc", 8'h5A, accumulator);
		chk_byte("target status", 8'h19, status);
		do_reset(2);
		at_edge(10);
		chk_byte("restart acc", 8'h3A, accumulator);
		tally_and_finish();
	end
endmodule : harvard_core_tb
